// File: hw/xts_core.sv
// Execute unit for bit-clear skip, table reads and XOR, with a bus slave.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] Bit-test skip skips next instruction when selected data bit is zero.
// [RULE2] A taken skip adds two dummy cycles, three instruction cycles in all.
// [RULE3] Page read: page and low pointer; low byte to data, high to latch.
// [RULE4] Last-page read uses last page and low pointer; same byte split.
// [RULE5] Incrementing page read bumps low pointer, then reads and splits.
// [RULE6] Incrementing last-page read bumps low pointer, then reads last page.
// [RULE7] XOR to working register stores working XOR data; only zero flag.
// [RULE8] XOR to memory writes working XOR data back to data byte.
// [RULE9] Skip and table reads keep flags; zero flag follows XOR result.
module xts_core (
   input  wire logic        I_CLK,
   input  wire logic        I_RSTN,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic             O_WB_ACK,
   output logic      [31:0] O_WB_DAT,
   output logic      [15:0] O_PMEM_ADDR,
   output logic             O_PMEM_RD,
   input  wire logic [15:0] I_PMEM_DATA,
   output logic             O_BUSY,
   output logic             O_SKIP,
   output logic             O_ZERO
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      xts_pkg::xts_state_t state;
      xts_pkg::xts_op_t    op;
      logic [2:0]          bsel;
      logic [3:0]          addr;
      logic [7:0]          work;
      logic [7:0]          page;
      logic [7:0]          low;
      logic [7:0]          hlat;
      logic                zero;
      logic                skip;
      logic                busy;
      logic [15:0]         paddr;
      logic                prd;
      logic                ack;
      logic [31:0]         rdat;
   } xts_core_state_t;

   xts_core_state_t r_reg;
   xts_core_state_t r_next;

   logic       wb_go;
   logic       dm_we;
   logic [3:0] dm_waddr;
   logic [7:0] dm_wdata;
   logic [7:0] dm_rdata_a;
   logic [7:0] dm_rdata_b;
   logic [7:0] xor_res;
   logic [7:0] low_inc;

   xts_dmem u_dmem (
      .i_clk     (I_CLK),
      .i_rstn    (I_RSTN),
      .i_we      (dm_we),
      .i_waddr   (dm_waddr),
      .i_wdata   (dm_wdata),
      .i_raddr_a (r_reg.addr),
      .o_rdata_a (dm_rdata_a),
      .i_raddr_b (I_WB_ADR[5:2]),
      .o_rdata_b (dm_rdata_b)
   );

   assign xor_res = r_reg.work ^ dm_rdata_a;
   assign low_inc = r_reg.low + 8'h01;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Bus writes are ignored while an instruction runs, so the operands
   // an instruction sees cannot change under it.
   always_comb begin
      r_next     = r_reg;
      r_next.ack = 1'b0;
      r_next.prd = 1'b0;
      dm_we      = 1'b0;
      dm_waddr   = r_reg.addr;
      dm_wdata   = 8'h00;
      wb_go      = I_WB_CYC && I_WB_STB && !r_reg.ack;

      if (wb_go) begin
         r_next.ack  = 1'b1;
         r_next.rdat = 32'h0000_0000;
         if (I_WB_ADR[7:6] == xts_pkg::ADR_DMEM_HI) begin
            r_next.rdat[7:0] = dm_rdata_b;
         end else begin
            case (I_WB_ADR)
               xts_pkg::ADR_ISSUE: begin
                  r_next.rdat[xts_pkg::IS_OP_LSB +: 3]  = r_reg.op;
                  r_next.rdat[xts_pkg::IS_BIT_LSB +: 3] = r_reg.bsel;
                  r_next.rdat[xts_pkg::IS_ADR_LSB +: 4] = r_reg.addr;
               end
               xts_pkg::ADR_STATUS: begin
                  r_next.rdat[xts_pkg::STB_BUSY] = r_reg.busy;
                  r_next.rdat[xts_pkg::STB_ZERO] = r_reg.zero;
                  r_next.rdat[xts_pkg::STB_SKIP] = r_reg.skip;
               end
               xts_pkg::ADR_WORK: r_next.rdat[7:0] = r_reg.work;
               xts_pkg::ADR_PAGE: r_next.rdat[7:0] = r_reg.page;
               xts_pkg::ADR_LOW:  r_next.rdat[7:0] = r_reg.low;
               xts_pkg::ADR_HLAT: r_next.rdat[7:0] = r_reg.hlat;
               default:           r_next.rdat      = 32'h0000_0000;
            endcase
         end
      end

      if (wb_go && I_WB_WE && !r_reg.busy) begin
         if (I_WB_ADR[7:6] == xts_pkg::ADR_DMEM_HI) begin
            dm_we    = I_WB_SEL[0];
            dm_waddr = I_WB_ADR[5:2];
            dm_wdata = I_WB_DAT[7:0];
         end else begin
            case (I_WB_ADR)
               xts_pkg::ADR_ISSUE: begin
                  if (I_WB_SEL[1:0] == xts_pkg::ISSUE_SEL &&
                      I_WB_DAT[2:0] != xts_pkg::OP_NONE) begin
                     r_next.op    = xts_pkg::xts_op_t'(I_WB_DAT[2:0]);
                     r_next.bsel  = I_WB_DAT[xts_pkg::IS_BIT_LSB +: 3];
                     r_next.addr  = I_WB_DAT[xts_pkg::IS_ADR_LSB +: 4];
                     r_next.state = xts_pkg::ST_EXEC;
                  end
               end
               xts_pkg::ADR_WORK: begin
                  if (I_WB_SEL[0]) r_next.work = I_WB_DAT[7:0];
               end
               xts_pkg::ADR_PAGE: begin
                  if (I_WB_SEL[0]) r_next.page = I_WB_DAT[7:0];
               end
               xts_pkg::ADR_LOW: begin
                  if (I_WB_SEL[0]) r_next.low = I_WB_DAT[7:0];
               end
               default: begin
               end
            endcase
         end
      end

      case (r_reg.state)
         xts_pkg::ST_IDLE: begin
         end
         xts_pkg::ST_EXEC: begin
            r_next.state = xts_pkg::ST_IDLE;
            case (r_reg.op)
               xts_pkg::OP_SKIP_CLR: begin
                  r_next.skip = !dm_rdata_a[r_reg.bsel];        // RULE1
                  if (!dm_rdata_a[r_reg.bsel]) begin
                     r_next.state = xts_pkg::ST_DUMMY1;          // RULE2
                  end
               end
               xts_pkg::OP_PAGE_RD: begin
                  r_next.paddr = {r_reg.page, r_reg.low};        // RULE3
                  r_next.prd   = 1'b1;
                  r_next.state = xts_pkg::ST_TBL_REQ;
               end
               xts_pkg::OP_LASTPAGE_RD: begin
                  r_next.paddr = {xts_pkg::LAST_PAGE, r_reg.low}; // RULE4
                  r_next.prd   = 1'b1;
                  r_next.state = xts_pkg::ST_TBL_REQ;
               end
               xts_pkg::OP_INC_PAGE_RD: begin
                  r_next.low   = low_inc;                        // RULE5
                  r_next.paddr = {r_reg.page, low_inc};          // RULE5
                  r_next.prd   = 1'b1;
                  r_next.state = xts_pkg::ST_TBL_REQ;
               end
               xts_pkg::OP_INC_LAST_RD: begin
                  r_next.low   = low_inc;                        // RULE6
                  r_next.paddr = {xts_pkg::LAST_PAGE, low_inc};  // RULE6
                  r_next.prd   = 1'b1;
                  r_next.state = xts_pkg::ST_TBL_REQ;
               end
               xts_pkg::OP_XOR_WORK: begin
                  r_next.work = xor_res;                         // RULE7
                  r_next.zero = (xor_res == 8'h00);              // RULE9
               end
               xts_pkg::OP_XOR_MEM: begin
                  dm_we       = 1'b1;                            // RULE8
                  dm_waddr    = r_reg.addr;
                  dm_wdata    = xor_res;
                  r_next.zero = (xor_res == 8'h00);              // RULE9
               end
               default: begin
               end
            endcase
         end
         xts_pkg::ST_DUMMY1: r_next.state = xts_pkg::ST_DUMMY2;
         xts_pkg::ST_DUMMY2: r_next.state = xts_pkg::ST_IDLE;
         xts_pkg::ST_TBL_REQ: r_next.state = xts_pkg::ST_TBL_CAP;
         xts_pkg::ST_TBL_CAP: begin
            // Program memory answers one cycle after the read strobe.
            dm_we        = 1'b1;                                 // RULE3
            dm_waddr     = r_reg.addr;
            dm_wdata     = I_PMEM_DATA[7:0];
            r_next.hlat  = I_PMEM_DATA[15:8];                    // RULE3
            r_next.state = xts_pkg::ST_IDLE;
         end
         default: r_next.state = xts_pkg::ST_IDLE;
      endcase

      r_next.busy = (r_next.state != xts_pkg::ST_IDLE);
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         r_reg       <= '0;
         r_reg.state <= xts_pkg::ST_IDLE;
         r_reg.op    <= xts_pkg::OP_NONE;
         r_reg.work  <= xts_pkg::RST_BYTE;
         r_reg.page  <= xts_pkg::RST_BYTE;
         r_reg.low   <= xts_pkg::RST_BYTE;
         r_reg.hlat  <= xts_pkg::RST_BYTE;
         r_reg.paddr <= xts_pkg::RST_WORD;
      end else begin
         r_reg <= r_next;
      end
   end

   assign O_WB_ACK    = r_reg.ack;
   assign O_WB_DAT    = r_reg.rdat;
   assign O_PMEM_ADDR = r_reg.paddr;
   assign O_PMEM_RD   = r_reg.prd;
   assign O_BUSY      = r_reg.busy;
   assign O_SKIP      = r_reg.skip;
   assign O_ZERO      = r_reg.zero;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   logic exec_skip;
   logic exec_tbl;
   assign exec_skip = r_reg.state == xts_pkg::ST_EXEC &&
                      r_reg.op == xts_pkg::OP_SKIP_CLR;
   assign exec_tbl  = r_reg.state == xts_pkg::ST_EXEC &&
                      r_reg.op inside {xts_pkg::OP_PAGE_RD,
                                       xts_pkg::OP_LASTPAGE_RD,
                                       xts_pkg::OP_INC_PAGE_RD,
                                       xts_pkg::OP_INC_LAST_RD};

   chk_skip_taken: assert property ( // RULE1
      exec_skip && !dm_rdata_a[r_reg.bsel] |=> O_SKIP)
      else $error("skip not taken on clear bit");
   chk_skip_cycles: assert property ( // RULE2
      $rose(O_BUSY) && r_reg.op == xts_pkg::OP_SKIP_CLR &&
      !dm_rdata_a[r_reg.bsel] |-> O_BUSY[*3] ##1 !O_BUSY)
      else $error("taken skip did not last three cycles");
   chk_noskip_one: assert property ( // RULE1
      exec_skip && dm_rdata_a[r_reg.bsel] |=> !O_SKIP && !O_BUSY)
      else $error("set bit did not fall through in one cycle");
   chk_page_addr: assert property ( // RULE3
      exec_tbl && r_reg.op == xts_pkg::OP_PAGE_RD
      |=> O_PMEM_RD && O_PMEM_ADDR == {r_reg.page, r_reg.low})
      else $error("page table address wrong");
   chk_last_addr: assert property ( // RULE4
      exec_tbl && r_reg.op == xts_pkg::OP_LASTPAGE_RD
      |=> O_PMEM_ADDR == {xts_pkg::LAST_PAGE, $past(r_reg.low)})
      else $error("last page table address wrong");
   chk_inc_first: assert property ( // RULE5
      exec_tbl && r_reg.op inside {xts_pkg::OP_INC_PAGE_RD,
                                   xts_pkg::OP_INC_LAST_RD}
      |=> r_reg.low == $past(r_reg.low) + 8'h01 &&
          O_PMEM_ADDR[7:0] == r_reg.low)
      else $error("low pointer not incremented before fetch");
   chk_inc_last: assert property ( // RULE6
      exec_tbl && r_reg.op == xts_pkg::OP_INC_LAST_RD
      |=> O_PMEM_ADDR[15:8] == xts_pkg::LAST_PAGE)
      else $error("incrementing last page read left last page");
   chk_tbl_split: assert property ( // RULE3
      r_reg.state == xts_pkg::ST_TBL_CAP
      |-> dm_we && dm_wdata == I_PMEM_DATA[7:0]
          ##1 r_reg.hlat == $past(I_PMEM_DATA[15:8]))
      else $error("table word split wrong");
   chk_xor_work: assert property ( // RULE7
      r_reg.state == xts_pkg::ST_EXEC && r_reg.op == xts_pkg::OP_XOR_WORK
      |=> r_reg.work == ($past(r_reg.work) ^ $past(dm_rdata_a)))
      else $error("xor to working register wrong");
   chk_xor_mem: assert property ( // RULE8
      r_reg.state == xts_pkg::ST_EXEC && r_reg.op == xts_pkg::OP_XOR_MEM
      |-> dm_we && dm_wdata == xor_res ##1 r_reg.work == $past(r_reg.work))
      else $error("xor to memory wrong");
   chk_zero_flag: assert property ( // RULE9
      r_reg.state == xts_pkg::ST_EXEC &&
      r_reg.op inside {xts_pkg::OP_XOR_WORK, xts_pkg::OP_XOR_MEM}
      |=> O_ZERO == ($past(xor_res) == 8'h00))
      else $error("zero flag does not follow xor result");
   chk_flags_hold: assert property ( // RULE9
      (exec_skip || exec_tbl) |-> ##1 $stable(O_ZERO) [*3])
      else $error("zero flag moved on skip or table read");

   cov_skip_taken: cover property (exec_skip && !dm_rdata_a[r_reg.bsel]);
   cov_inc_wrap:   cover property (exec_tbl && r_reg.low == 8'hFF &&
                                   r_reg.op == xts_pkg::OP_INC_PAGE_RD);
   cov_xor_zero:   cover property (r_reg.state == xts_pkg::ST_EXEC &&
                                   r_reg.op == xts_pkg::OP_XOR_MEM &&
                                   xor_res == 8'h00);

endmodule : xts_core

`default_nettype wire

// File: hw/xts_dmem.sv
// Small data memory held in flip-flops, one write port and two read ports.
`timescale 1ns/1ps
`default_nettype none

module xts_dmem (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_we,
   input  wire logic [3:0] i_waddr,
   input  wire logic [7:0] i_wdata,
   input  wire logic [3:0] i_raddr_a,
   output logic      [7:0] o_rdata_a,
   input  wire logic [3:0] i_raddr_b,
   output logic      [7:0] o_rdata_b
);

   typedef struct packed {
      logic [xts_pkg::DMEM_DEPTH-1:0][7:0] mem;
   } xts_dmem_state_t;

   xts_dmem_state_t s_reg;
   xts_dmem_state_t s_next;
   logic [xts_pkg::DMEM_DEPTH-1:0][7:0] entry_next;

   genvar k;
   generate
      for (k = 0; k < xts_pkg::DMEM_DEPTH; k = k + 1) begin : g_entry
         assign entry_next[k] = (i_we && i_waddr == 4'(k)) ? i_wdata
                                                            : s_reg.mem[k];
      end
   endgenerate

   always_comb begin
      s_next     = s_reg;
      s_next.mem = entry_next;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata_a = s_reg.mem[i_raddr_a];
   assign o_rdata_b = s_reg.mem[i_raddr_b];

endmodule : xts_dmem

`default_nettype wire

// File: include/xts_pkg.sv
// Constants, register map and enumerations for the extended execute block.
package xts_pkg;

   // --------------------------------------------------------------------
   // Register byte offsets on the bus
   // --------------------------------------------------------------------
   localparam logic [7:0] ADR_ISSUE  = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_WORK   = 8'h08;
   localparam logic [7:0] ADR_PAGE   = 8'h0C;
   localparam logic [7:0] ADR_LOW    = 8'h10;
   localparam logic [7:0] ADR_HLAT   = 8'h14;
   localparam logic [1:0] ADR_DMEM_HI = 2'h1;

   // --------------------------------------------------------------------
   // Field positions, memory size, fixed values and values after reset
   // --------------------------------------------------------------------
   localparam int IS_OP_LSB  = 0;
   localparam int IS_BIT_LSB = 4;
   localparam int IS_ADR_LSB = 8;
   localparam int STB_BUSY   = 0;
   localparam int STB_ZERO   = 1;
   localparam int STB_SKIP   = 2;
   localparam int DMEM_DEPTH = 16;
   localparam int DMEM_AW    = 4;
   localparam logic [7:0]  LAST_PAGE = 8'hFF;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [1:0]  ISSUE_SEL = 2'h3;

   // --------------------------------------------------------------------
   // Instruction and sequencer encodings
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE          = 3'h0,
      OP_SKIP_CLR      = 3'h1,
      OP_PAGE_RD       = 3'h2,
      OP_LASTPAGE_RD   = 3'h3,
      OP_INC_PAGE_RD   = 3'h4,
      OP_INC_LAST_RD   = 3'h5,
      OP_XOR_WORK      = 3'h6,
      OP_XOR_MEM       = 3'h7
   } xts_op_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_EXEC    = 3'h1,
      ST_DUMMY1  = 3'h2,
      ST_DUMMY2  = 3'h3,
      ST_TBL_REQ = 3'h4,
      ST_TBL_CAP = 3'h5
   } xts_state_t;

endpackage : xts_pkg

// File: verification/tb_top.sv
// Self-checking bench for the extended execute block over its bus.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        I_CLK    = 1'b0;
   logic        I_RSTN   = 1'b0;
   logic        I_WB_CYC = 1'b0;
   logic        I_WB_STB = 1'b0;
   logic        I_WB_WE  = 1'b0;
   logic [7:0]  I_WB_ADR = 8'h00;
   logic [3:0]  I_WB_SEL = 4'h0;
   logic [31:0] I_WB_DAT = 32'h00000000;
   logic        O_WB_ACK;
   logic [31:0] O_WB_DAT;
   logic [15:0] O_PMEM_ADDR;
   logic        O_PMEM_RD;
   logic [15:0] I_PMEM_DATA;
   logic        O_BUSY;
   logic        O_SKIP;
   logic        O_ZERO;
   int          num_errors  = 0;
   int          comparisons = 0;
   int          rd_pulses   = 0;

   always #25 I_CLK = ~I_CLK;

   // Each table read must raise the program read strobe exactly once.
   always @(posedge I_CLK) begin
      if (O_PMEM_RD === 1'b1) begin
         rd_pulses <= rd_pulses + 1;
      end
   end

   xts_core dut_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
      .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
      .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK),
      .O_WB_DAT(O_WB_DAT), .O_PMEM_ADDR(O_PMEM_ADDR),
      .O_PMEM_RD(O_PMEM_RD), .I_PMEM_DATA(I_PMEM_DATA),
      .O_BUSY(O_BUSY), .O_SKIP(O_SKIP), .O_ZERO(O_ZERO));

   xts_pmem_model pmem_u (.i_clk(I_CLK), .i_rd(O_PMEM_RD),
      .i_addr(O_PMEM_ADDR), .o_data(I_PMEM_DATA));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] word(input logic [15:0] a);
      return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
   endfunction : word

   function automatic logic [7:0] dm(input logic [3:0] a);
      return {2'b01, a, 2'b00};
   endfunction : dm

   // Classic single cycle: request held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge I_CLK);
      I_WB_CYC <= 1'b1;
      I_WB_STB <= 1'b1;
      I_WB_WE  <= we;
      I_WB_ADR <= adr;
      I_WB_DAT <= dat;
      I_WB_SEL <= 4'hF;
      do begin
         @(posedge I_CLK);
         n++;
      end while (O_WB_ACK !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("mismatch bus ack expected 1 seen timeout");
         stop_test();
      end
      rd = O_WB_DAT;
      I_WB_CYC <= 1'b0;
      I_WB_STB <= 1'b0;
      I_WB_WE  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      logic [31:0] d;
      wb(1'b1, adr, {24'h000000, dat}, d);
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] d);
      wb(1'b0, adr, 32'h00000000, d);
   endtask : rd

   // Issues one instruction and counts the cycles that busy stays high.
   task automatic run(input logic [2:0] op, input logic [2:0] b,
                      input logic [3:0] a, output int n);
      logic [31:0] d;
      wb(1'b1, xts_pkg::ADR_ISSUE, {20'h00000, a, 1'b0, b, 1'b0, op}, d);
      n = 0;
      while (O_BUSY === 1'b1 && n < 20) begin
         n++;
         @(posedge I_CLK);
      end
      if (n >= 20) begin
         num_errors++;
         $display("mismatch busy expected 0 seen timeout");
         stop_test();
      end
   endtask : run

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      int          n;
      logic [15:0] pa;
      logic [7:0]  lo;
      logic [7:0]  lows [4];
      lows = '{8'h34, 8'h80, 8'hFF, 8'h7F};
      repeat (8) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      rd(xts_pkg::ADR_STATUS, d);
      check("status after reset", d, 32'h00000000);
      rd(8'h30, d);
      check("unmapped read", d, 32'h00000000);
      // XOR into the working register, result zero.
      wr(xts_pkg::ADR_WORK, 8'h5A);
      wr(dm(4'h3), 8'h5A);
      run(xts_pkg::OP_XOR_WORK, 3'h0, 4'h3, n);
      check("xor work cycles", n, 32'h1);
      rd(xts_pkg::ADR_WORK, d);
      check("xor work value", d, 32'h00000000);
      check("zero after xor work", O_ZERO, 32'h1);
      // XOR into memory, nonzero then zero.
      wr(xts_pkg::ADR_WORK, 8'h3C);
      wr(dm(4'h3), 8'h0F);
      run(xts_pkg::OP_XOR_MEM, 3'h0, 4'h3, n);
      rd(dm(4'h3), d);
      check("xor mem value", d, 32'h00000033);
      check("zero after xor mem", O_ZERO, 32'h0);
      rd(xts_pkg::ADR_WORK, d);
      check("work kept by xor mem", d, 32'h0000003C);
      wr(dm(4'h3), 8'h3C);
      run(xts_pkg::OP_XOR_MEM, 3'h0, 4'h3, n);
      rd(dm(4'h3), d);
      check("xor mem zero", d, 32'h00000000);
      check("zero set by xor mem", O_ZERO, 32'h1);
      // Skip test over every bit; only bit 4 of the byte is clear.
      wr(dm(4'h2), 8'hEF);
      for (int i = 0; i < 8; i++) begin
         run(xts_pkg::OP_SKIP_CLR, 3'(i), 4'h2, n);
         check("skip flag", O_SKIP, {31'h0, (i == 4)});
         check("skip cycles", n, (i == 4) ? 32'h3 : 32'h1);
         check("zero kept by skip", O_ZERO, 32'h1);
      end
      // Table reads; the wrapping low pointer keeps the page.
      wr(xts_pkg::ADR_PAGE, 8'h12);
      for (int k = 0; k < 4; k++) begin
         wr(xts_pkg::ADR_LOW, lows[k]);
         run(3'(k + 2), 3'h0, 4'(k + 4), n);
         lo = lows[k] + ((k >= 2) ? 8'h01 : 8'h00);
         pa = {(k % 2 == 1) ? xts_pkg::LAST_PAGE : 8'h12, lo};
         check("table cycles", n, 32'h3);
         check("table address", O_PMEM_ADDR, pa);
         rd(dm(4'(k + 4)), d);
         check("table low byte", d, word(pa) & 16'h00FF);
         rd(xts_pkg::ADR_HLAT, d);
         check("table high byte", d, word(pa) >> 8);
         rd(xts_pkg::ADR_LOW, d);
         check("low pointer", d, {24'h000000, lo});
         rd(xts_pkg::ADR_PAGE, d);
         check("page pointer", d, 32'h00000012);
         check("zero kept by table", O_ZERO, 32'h1);
      end
      check("table read strobes", rd_pulses, 32'h4);
      check("read strobe idle", O_PMEM_RD, 32'h0);
      // The latch is read-only from the bus.
      wr(xts_pkg::ADR_HLAT, 8'hAA);
      rd(xts_pkg::ADR_HLAT, d);
      check("latch read-only", d, word(pa) >> 8);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire

// File: verification/xts_pmem_model.sv
// Behavioural program memory answering table reads one cycle late.
`timescale 1ns/1ps
`default_nettype none

module xts_pmem_model (
   input  wire logic        i_clk,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   output logic      [15:0] o_data
);
   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   // Outside the answer cycle the word toggles every clock, so a core
   // that samples late sees garbage rather than a lucky stale value.
   always @(posedge i_clk) begin
      if (i_rd) begin
         o_data <= {i_addr[7:0] ^ 8'h5A, i_addr[15:8] ^ 8'hC3};
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule : xts_pmem_model
`default_nettype wire
